/* src/hrs_consts.vh */
// What this block does
// - identification leaf 01H reports random-read support in bit 30 of result c.
// - identification leaf 07H subleaf 0 reports seed-read support in bit 18 of result b.
// - random read returns deterministic generator output, reseeded often from entropy.
// - seed read returns nondeterministic entropy output, not the deterministic generator.
// - self-test faults make the random read return no data.
// - self-test flagging bad entropy makes the seed read return no data.
// - random read over supply rate fails transiently with success flag clear.
// - seed read over entropy supply fails transiently with success flag clear.
// - valid random data is returned with success flag set.
// - valid seed data is returned with success flag set.
`ifndef HRS_CONSTS_VH
`define HRS_CONSTS_VH
`define HRS_NCORE          4
`define HRS_LEAF_BASIC     32'h0000_0001
`define HRS_LEAF_EXT       32'h0000_0007
`define HRS_SUBLEAF_EXT    32'h0000_0000
`define HRS_RAND_FEAT_BIT  30
`define HRS_SEED_FEAT_BIT  18
`define HRS_RESEED_COUNT   8'h3f
`define HRS_DETERMINISTIC_GENERATOR_SEED      64'h9e37_79b9_7f4a_7c15
`define HRS_LFSR_SEED      64'hd1b5_4a32_d192_ed03
`define HRS_STUCK_LIMIT    4'hf
`endif

/* src/hrs_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.vh"
module hrs_core (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [3:0]  randReq,
    input  wire [3:0]  seedReq,
    output wire [3:0]  reqReady,
    output reg  [3:0]  rspValid,
    output reg  [63:0] rspData,
    output reg         successFlag,
    input  wire [3:0]  rspReady,
    input  wire [31:0] queryLeaf,
    input  wire [31:0] querySubleaf,
    output reg  [31:0] queryResultB,
    output reg  [31:0] queryResultC,
    input  wire        entropyBit,
    output reg         selfTestFail
);
    // identification query
    always @* begin
        queryResultB = 32'h0000_0000;
        queryResultC = 32'h0000_0000;
        if (queryLeaf == `HRS_LEAF_BASIC) begin
            queryResultC[`HRS_RAND_FEAT_BIT] = 1'b1;
        end else if (queryLeaf == `HRS_LEAF_EXT && querySubleaf == `HRS_SUBLEAF_EXT) begin
            queryResultB[`HRS_SEED_FEAT_BIT] = 1'b1;
        end
    end

    // entropy pin synchroniser
    reg entSync1_r;
    reg entSync2_r;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            entSync1_r <= 1'b0;
            entSync2_r <= 1'b0;
        end else begin
            entSync1_r <= entropyBit;
            entSync2_r <= entSync1_r;
        end
    end

    // entropy pool: shifts raw bits, stirred with an lfsr so one bad bit is not fatal
    reg [63:0] pool_r;
    reg [5:0]  poolCnt_r;
    reg        poolFull_r;
    reg [3:0]  runLen_r;
    reg        lastBit_r;
    wire       seedTake;
    wire       reseedTake;
    wire [63:0] poolNxt = {pool_r[62:0], entSync2_r ^ pool_r[63] ^ pool_r[62]
                           ^ pool_r[60] ^ pool_r[59]};
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pool_r       <= `HRS_LFSR_SEED;
            poolCnt_r    <= 6'h00;
            poolFull_r   <= 1'b0;
            runLen_r     <= 4'h0;
            lastBit_r    <= 1'b0;
            selfTestFail <= 1'b0;
        end else begin
            pool_r    <= poolNxt;
            lastBit_r <= entSync2_r;
            // repetition test: a stuck source is a fault
            if (entSync2_r == lastBit_r) begin
                if (runLen_r != `HRS_STUCK_LIMIT)
                    runLen_r <= runLen_r + 4'h1;
            end else begin
                runLen_r <= 4'h0;
            end
            selfTestFail <= (runLen_r == `HRS_STUCK_LIMIT);
            if (seedTake || reseedTake) begin
                poolFull_r <= 1'b0;
                poolCnt_r  <= 6'h00;
            end else if (poolCnt_r == 6'h3f) begin
                poolFull_r <= 1'b1;
            end else begin
                poolCnt_r <= poolCnt_r + 6'h01;
            end
        end
    end

    // deterministic generator: xorshift state, reseeded from pool
    reg  [63:0] deterministic_generator_r;
    reg  [7:0]  useCnt_r;
    reg         drbgOk_r;
    wire [63:0] x1 = deterministic_generator_r ^ {deterministic_generator_r[50:0], 13'h0000};
    wire [63:0] x2 = x1 ^ {7'h00, x1[63:7]};
    wire [63:0] drbgNxt = x2 ^ {x2[46:0], 17'h00000};
    wire        randTake;
    // first seeding after reset must not wait on a use count that cannot advance
    assign reseedTake = poolFull_r && !selfTestFail
                        && (!drbgOk_r || (useCnt_r == `HRS_RESEED_COUNT));
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            deterministic_generator_r   <= `HRS_DETERMINISTIC_GENERATOR_SEED;
            useCnt_r <= 8'h00;
            drbgOk_r <= 1'b0;
        end else begin
            if (reseedTake) begin
                deterministic_generator_r   <= drbgNxt ^ pool_r;
                useCnt_r <= 8'h00;
                drbgOk_r <= 1'b1;
            end else if (randTake) begin
                deterministic_generator_r <= drbgNxt;
                if (useCnt_r == `HRS_RESEED_COUNT)
                    drbgOk_r <= 1'b0; // starved of reseed: refuse until fresh
                else
                    useCnt_r <= useCnt_r + 8'h01;
            end
        end
    end

    // round-robin arbiter over cores, at most one grant every two cycles
    localparam ST_IDLE = 1'b0;
    localparam ST_HOLD = 1'b1;
    reg        state_r;
    reg [1:0]  ptr_r;
    reg [1:0]  grant;
    reg        anyReq;
    reg        grantSeed;
    integer    k;
    reg [1:0]  idx;
    always @* begin
        grant     = 2'd0;
        anyReq    = 1'b0;
        grantSeed = 1'b0;
        idx       = 2'd0;
        for (k = 3; k >= 0; k = k - 1) begin
            idx = ptr_r + k[1:0];
            if (randReq[idx] || seedReq[idx]) begin
                grant     = idx;
                anyReq    = 1'b1;
                grantSeed = seedReq[idx];
            end
        end
    end

    // two-entry output buffer so a stalled core loses no word
    reg [63:0] bufData_r [0:1];
    reg        bufOk_r   [0:1];
    reg [1:0]  bufCore_r [0:1];
    reg        wrPtr_r;
    reg        rdPtr_r;
    reg [1:0]  count_r;
    wire bufFull  = (count_r == 2'd2);
    wire bufEmpty = (count_r == 2'd0);
    wire accept   = anyReq && !bufFull && (state_r == ST_IDLE);
    wire okSeed   = poolFull_r && !selfTestFail;
    wire okRand   = drbgOk_r && !selfTestFail && !reseedTake;
    wire grantOk  = grantSeed ? okSeed : okRand;
    assign seedTake = accept && grantSeed && okSeed;
    assign randTake = accept && !grantSeed && okRand;
    wire pop = !bufEmpty && rspReady[bufCore_r[rdPtr_r]];

    genvar g;
    generate
        for (g = 0; g < `HRS_NCORE; g = g + 1) begin : gReady
            assign reqReady[g] = accept && (grant == g);
        end
    endgenerate

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r      <= ST_IDLE;
            ptr_r        <= 2'd0;
            wrPtr_r      <= 1'b0;
            rdPtr_r      <= 1'b0;
            count_r      <= 2'd0;
            bufData_r[0] <= 64'h0;
            bufData_r[1] <= 64'h0;
            bufOk_r[0]   <= 1'b0;
            bufOk_r[1]   <= 1'b0;
            bufCore_r[0] <= 2'd0;
            bufCore_r[1] <= 2'd0;
        end else begin
            case (state_r)
                ST_IDLE: if (accept) state_r <= ST_HOLD;
                ST_HOLD: state_r <= ST_IDLE; // gap lets requester drop its strobe
                default: state_r <= ST_IDLE;
            endcase
            if (accept) begin
                ptr_r               <= grant + 2'd1;
                // failure returns zero data, never stale or flagged words
                bufData_r[wrPtr_r]  <= grantOk ? (grantSeed ? pool_r : deterministic_generator_r) : 64'h0;
                bufOk_r[wrPtr_r]    <= grantOk;
                bufCore_r[wrPtr_r]  <= grant;
                wrPtr_r             <= ~wrPtr_r;
            end
            if (pop)
                rdPtr_r <= ~rdPtr_r;
            count_r <= count_r + {1'b0, accept} - {1'b0, pop};
        end
    end

    always @* begin
        rspValid    = 4'h0;
        rspData     = bufData_r[rdPtr_r];
        successFlag = bufOk_r[rdPtr_r] && !bufEmpty;
        if (!bufEmpty)
            rspValid[bufCore_r[rdPtr_r]] = 1'b1;
    end
endmodule
`default_nettype wire

/* verification/hrs_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module hrs_core_assertions (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [3:0]  randReq,
    input wire logic [3:0]  seedReq,
    input wire logic [3:0]  reqReady,
    input wire logic [3:0]  rspValid,
    input wire logic [63:0] rspData,
    input wire logic        successFlag,
    input wire logic [3:0]  rspReady,
    input wire logic [31:0] queryLeaf,
    input wire logic [31:0] querySubleaf,
    input wire logic [31:0] queryResultB,
    input wire logic [31:0] queryResultC,
    input wire logic        selfTestFail
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_leaf_basic: assert property (queryLeaf == 32'h1 |-> queryResultC[30])
        else $error("random support bit clear");
    a_leaf_ext: assert property (queryLeaf == 32'h7 && querySubleaf == 32'h0 |-> queryResultB[18])
        else $error("seed support bit clear");
    a_fail_zero: assert property (|rspValid && !successFlag |-> rspData == 64'h0)
        else $error("failed answer carries data");
    a_rsp_hold: assert property (|rspValid && !(|(rspValid & rspReady))
        |=> $stable(rspValid) && $stable(rspData) && $stable(successFlag))
        else $error("answer changed before accept");
    a_answer_soon: assert property (|reqReady && rspValid == 4'h0 |=> rspValid == $past(reqReady))
        else $error("answer late or wrong core");
    a_grant_one: assert property ($onehot0(reqReady) && $onehot0(rspValid))
        else $error("more than one core at once");
    a_grant_req: assert property ((reqReady & ~(randReq | seedReq)) == 4'h0)
        else $error("grant without request");
    a_grant_gap: assert property (|reqReady |=> reqReady == 4'h0)
        else $error("accepts too close");
    a_fault_nodata: assert property (selfTestFail && |reqReady && rspValid == 4'h0 |=> !successFlag)
        else $error("data delivered during fault");
endmodule
bind hrs_core hrs_core_assertions u_chk (.mclk, .rst_b, .randReq, .seedReq, .reqReady,
    .rspValid, .rspData, .successFlag, .rspReady, .queryLeaf, .querySubleaf, .queryResultB,
    .queryResultC, .selfTestFail);
`default_nettype wire

/* verification/hrs_core_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module hrs_core_partner (
    input  wire logic       mclk,
    input  wire logic [3:0] wantRand,
    input  wire logic [3:0] wantSeed,
    input  wire logic       stall,
    input  wire logic [3:0] reqReady,
    input  wire logic [3:0] rspValid,
    output var  logic [3:0] randReq = 4'h0,
    output var  logic [3:0] seedReq = 4'h0,
    output wire logic [3:0] rspReady
);
    // requests held until the accept pulse
    always @(posedge mclk) begin
        randReq <= (randReq & ~reqReady) | wantRand;
        seedReq <= (seedReq & ~reqReady) | wantSeed;
    end
    assign rspReady = stall ? 4'h0 : rspValid;
endmodule
`default_nettype wire

/* verification/hrs_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) compares++; if ((a) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, a); end
module hrs_core_tb;
    logic mclk, rst_b, stall, bad, entropyBit, successFlag, selfTestFail;
    logic [3:0] wantRand, wantSeed, randReq, seedReq, reqReady, rspValid, rspReady, done, flagOf;
    logic [63:0] rspData, dataOf [4], seen [$];
    logic [31:0] queryLeaf, querySubleaf, queryResultB, queryResultC;
    logic [7:0] cnt;
    int errors, compares, acc;
    hrs_core dut (.mclk, .rst_b, .randReq, .seedReq, .reqReady, .rspValid, .rspData,
        .successFlag, .rspReady, .queryLeaf, .querySubleaf, .queryResultB, .queryResultC,
        .entropyBit, .selfTestFail);
    hrs_core_partner cores (.mclk, .wantRand, .wantSeed, .stall, .reqReady, .rspValid,
        .randReq, .seedReq, .rspReady);
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    // short runs only, so the stuck detector never trips on good data
    always @(negedge mclk) cnt <= cnt + 8'h1;
    assign entropyBit = bad | (cnt[0] ^ cnt[3] ^ cnt[6]);
    always @(posedge mclk) begin
        acc += |reqReady;
        for (int i = 0; i < 4; i++) if (rspValid[i] && rspReady[i]) begin
            flagOf[i] = successFlag;
            dataOf[i] = rspData;
            done[i] = 1'b1;
        end
    end
    task automatic ask(input logic [3:0] r, input logic [3:0] s);
        done = 4'h0;
        wantRand = r;
        wantSeed = s;
        @(negedge mclk);
        wantRand = 4'h0;
        wantSeed = 4'h0;
    endtask
    task automatic wait_done(input logic [3:0] m);
        for (int k = 0; k < 300 && done !== m; k++) @(negedge mclk);
    endtask
    task automatic t_query();
        queryLeaf = 32'h1;
        @(negedge mclk);
        `CHK("leaf1 bit30", 1'b1, queryResultC[30])
        `CHK("leaf1 result b", 32'h0, queryResultB)
        queryLeaf = 32'h7;
        @(negedge mclk);
        `CHK("leaf7 bit18", 1'b1, queryResultB[18])
        `CHK("leaf7 result c", 32'h0, queryResultC)
        querySubleaf = 32'h1;
        @(negedge mclk);
        `CHK("leaf7 sub1 bit18", 1'b0, queryResultB[18])
        querySubleaf = 32'h0;
    endtask
    task automatic t_fill();
        stall = 1;
        acc = 0;
        ask(4'hf, 4'h0);
        repeat (20) @(negedge mclk);
        `CHK("accepts while stalled", 2, acc)
        stall = 0;
        wait_done(4'hf);
        `CHK("all drained", 4'hf, done)
    endtask
    task automatic t_fetch(input logic sd);
        logic [3:0] pend;
        int dup;
        pend = 4'hf;
        // a bounded retry loop, as software would run it
        for (int n = 0; n < 10 && pend != 4'h0; n++) begin
            ask(sd ? 4'h0 : pend, sd ? pend : 4'h0);
            wait_done(pend);
            for (int i = 0; i < 4; i++) if (pend[i] && flagOf[i]) begin
                dup = 0;
                foreach (seen[k]) dup += (seen[k] === dataOf[i]);
                `CHK("distinct word", 0, dup)
                seen.push_back(dataOf[i]);
                pend[i] = 1'b0;
            end
            // one pool fill feeds one seed, so the other cores must be turned away
            if (n == 0 && sd) begin
                `CHK("seed starved", 1'b1, pend != 4'h0)
            end
            repeat (80) @(negedge mclk);
        end
        `CHK("served cores", 4'h0, pend)
    endtask
    task automatic t_fault();
        bad = 1;
        repeat (40) @(negedge mclk);
        `CHK("self test", 1'b1, selfTestFail)
        ask(4'h1, 4'h2);
        wait_done(4'h3);
        `CHK("rand flag", 1'b0, flagOf[0])
        `CHK("rand data", 64'h0, dataOf[0])
        `CHK("seed flag", 1'b0, flagOf[1])
        `CHK("seed data", 64'h0, dataOf[1])
    endtask
    task automatic give_verdict();
        if (errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rst_b, stall, bad, wantRand, wantSeed, cnt, queryLeaf, querySubleaf} = '0;
        repeat (5) @(negedge mclk);
        rst_b = 1;
        t_query();
        repeat (300) @(negedge mclk);
        t_fill();
        t_fetch(1'b0);
        t_fetch(1'b1);
        t_fault();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
